// ---- core/ppc_consts.svh ----
`ifndef PPC_CONSTS_SVH
`define PPC_CONSTS_SVH
// register indices, byte address is four times the index
`define PPC_IDX_BLOCKS 8'h1A
`define PPC_IDX_COUNTS 8'h1B
`define PPC_IDX_TUNE 8'h1F
`define PPC_IDX_STATUS 8'h20
`define PPC_IDX_SLOPE_LO 8'h21
// reset values
`define PPC_RST_BLOCKS 8'h00
`define PPC_RST_COUNTS 8'h00
`define PPC_RST_TUNE 8'h20
`define PPC_RST_SLOPE_LO 8'h00
// field positions
`define PPC_SLOPE_HI_LSB 0
`define PPC_SET1_BLK_LSB 2
`define PPC_SET2_BLK_LSB 5
`define PPC_SET1_CNT_LSB 0
`define PPC_SET2_CNT_LSB 4
`define PPC_CAP_LSB 0
`define PPC_DUTY_SEL_LSB 4
`define PPC_DUTY_OFF_BIT 6
// stage layout
`define PPC_MAX_STAGES 4'hB
`define PPC_BLK0_STAGES 9
// capacitor bank unit
`define PPC_CAP_UNIT_FF 10'h03C
// inserted delay in ps, per band and duty code
`define PPC_DLY_B1_C0 9'h045
`define PPC_DLY_B1_C1 9'h0CF
`define PPC_DLY_B1_C2 9'h15A
`define PPC_DLY_B1_C3 9'h1E4
`define PPC_DLY_B2_C0 9'h023
`define PPC_DLY_B2_C1 9'h068
`define PPC_DLY_B2_C2 9'h0AD
`define PPC_DLY_B2_C3 9'h0F2
`define PPC_DLY_B3_C0 9'h021
`define PPC_DLY_B3_C1 9'h062
`define PPC_DLY_B3_C2 9'h0A4
`define PPC_DLY_B3_C3 9'h0E6
`endif

// ---- core/ppc_pkg.sv ----
package ppc_pkg;
    // one output power setting
    typedef struct packed {
        logic [2:0] blocks;
        logic [3:0] count;
    } ppc_pwr_set_s;
    // what reaches the amplifier and tuning network
    typedef struct packed {
        logic [10:0] stage_en;
        logic [2:0] blocks;
        logic pa_on;
        logic [8:0] delay_ps;
        logic [3:0] cap_sel;
        logic [9:0] cap_ff;
        logic [10:0] slope_ratio;
    } ppc_pa_drive_s;
endpackage

// ---- core/ppc_power_config_regs.sv ----
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "ppc_consts.svh"
module ppc_power_config_regs
    import ppc_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // pins from the rest of the transmitter
    input wire logic [1:0] i_band_select,
    input wire logic i_set_select,
    input wire logic i_osc_settled,
    // amplifier drive
    output ppc_pa_drive_s o_pa_drive
);

    // =========================================================
    // functions
    function automatic logic [3:0] clamp_count(input logic [3:0] c);
        clamp_count = (c > `PPC_MAX_STAGES) ? `PPC_MAX_STAGES : c;
    endfunction

    function automatic logic [8:0] delay_lookup(input logic [1:0] band, input logic [1:0] code);
        logic [3:0] key;
        key = {band, code};
        case (key)
            4'h4: delay_lookup = `PPC_DLY_B1_C0;
            4'h5: delay_lookup = `PPC_DLY_B1_C1;
            4'h6: delay_lookup = `PPC_DLY_B1_C2;
            4'h7: delay_lookup = `PPC_DLY_B1_C3;
            4'h8: delay_lookup = `PPC_DLY_B2_C0;
            4'h9: delay_lookup = `PPC_DLY_B2_C1;
            4'hA: delay_lookup = `PPC_DLY_B2_C2;
            4'hB: delay_lookup = `PPC_DLY_B2_C3;
            4'hC: delay_lookup = `PPC_DLY_B3_C0;
            4'hD: delay_lookup = `PPC_DLY_B3_C1;
            4'hE: delay_lookup = `PPC_DLY_B3_C2;
            4'hF: delay_lookup = `PPC_DLY_B3_C3;
            default: delay_lookup = 9'h000;
        endcase
    endfunction

    // =========================================================
    // pin synchronisers, a change counts once stages two and three agree
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [3:0] pin_q;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
            pin_s3 <= 4'h0;
        end else begin
            pin_s1 <= {i_osc_settled, i_set_select, i_band_select};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_q <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (pin_s2[i] == pin_s3[i]) begin
                    pin_q[i] <= pin_s2[i];
                end
            end
        end
    end

    logic [1:0] band_q;
    logic set_q;
    logic osc_q;
    assign band_q = pin_q[1:0];
    assign set_q = pin_q[2];
    assign osc_q = pin_q[3];

    // =========================================================
    // apb decode
    logic [7:0] reg_idx;
    logic idx_ok;
    logic idx_mapped;
    logic writable;
    logic access_done;
    logic wr_en;

    // upper address bits must be clear, index sits above the byte lane bits
    assign reg_idx = i_paddr[9:2];
    assign idx_ok = (i_paddr[31:10] == 22'h0) && (i_paddr[1:0] == 2'h0);
    assign writable = (reg_idx == `PPC_IDX_BLOCKS) || (reg_idx == `PPC_IDX_COUNTS)
        || (reg_idx == `PPC_IDX_TUNE) || (reg_idx == `PPC_IDX_SLOPE_LO);
    assign idx_mapped = idx_ok && (writable || (reg_idx == `PPC_IDX_STATUS));
    assign access_done = i_psel && i_penable && o_pready;
    // no gating on the oscillator: the bus works from reset on
    assign wr_en = access_done && i_pwrite && idx_ok && writable && i_pstrb[0];

    // =========================================================
    // configuration registers
    logic [7:0] blocks_reg;
    logic [7:0] counts_reg;
    logic [7:0] tune_reg;
    logic [7:0] slope_lo_reg;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            blocks_reg <= `PPC_RST_BLOCKS;
            counts_reg <= `PPC_RST_COUNTS;
            tune_reg <= `PPC_RST_TUNE;
            slope_lo_reg <= `PPC_RST_SLOPE_LO;
        end else if (wr_en) begin
            case (reg_idx)
                `PPC_IDX_BLOCKS: blocks_reg <= i_pwdata[7:0];
                `PPC_IDX_COUNTS: counts_reg <= i_pwdata[7:0];
                // reserved top bit kept at zero
                `PPC_IDX_TUNE: tune_reg <= {1'b0, i_pwdata[6:0]};
                `PPC_IDX_SLOPE_LO: slope_lo_reg <= i_pwdata[7:0];
                default: ;
            endcase
        end
    end

    // one wait state so every answer comes from a flop
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pready <= 1'b0;
        end else begin
            o_pready <= i_psel && i_penable && !o_pready;
        end
    end

    logic [31:0] status_word;

    // config registers are write-only and read back as zero
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0;
            o_pslverr <= 1'b0;
        end else if (i_psel && i_penable && !o_pready) begin
            o_prdata <= (!i_pwrite && idx_ok && reg_idx == `PPC_IDX_STATUS) ? status_word : 32'h0;
            o_pslverr <= !idx_mapped || (i_pwrite && reg_idx == `PPC_IDX_STATUS);
        end else begin
            o_prdata <= 32'h0;
            o_pslverr <= 1'b0;
        end
    end

    // =========================================================
    // power setting selection and stage map
    ppc_pwr_set_s set1;
    ppc_pwr_set_s set2;
    ppc_pwr_set_s active;
    logic [3:0] stage_cnt;
    logic [10:0] next_stage_en;

    assign set1.blocks = blocks_reg[`PPC_SET1_BLK_LSB +: 3];
    assign set1.count = counts_reg[`PPC_SET1_CNT_LSB +: 4];
    assign set2.blocks = blocks_reg[`PPC_SET2_BLK_LSB +: 3];
    assign set2.count = counts_reg[`PPC_SET2_CNT_LSB +: 4];
    assign active = set_q ? set2 : set1;
    assign stage_cnt = clamp_count(active.count);

    always_comb begin
        next_stage_en = 11'h000;
        for (int i = 0; i < 11; i++) begin
            // stage i is lit when the count reaches past it and its block is on
            if (4'(i) < stage_cnt) begin
                if (i < `PPC_BLK0_STAGES) begin
                    next_stage_en[i] = active.blocks[0];
                end else if (i == `PPC_BLK0_STAGES) begin
                    next_stage_en[i] = active.blocks[1];
                end else begin
                    next_stage_en[i] = active.blocks[2];
                end
            end
        end
    end

    // =========================================================
    // duty delay, slope divider and tuning
    logic duty_off;
    logic [1:0] duty_sel;
    logic [3:0] cap_sel;
    logic [8:0] next_delay;
    logic [9:0] next_cap_ff;
    logic [10:0] next_slope;

    assign duty_off = tune_reg[`PPC_DUTY_OFF_BIT];
    assign duty_sel = tune_reg[`PPC_DUTY_SEL_LSB +: 2];
    assign cap_sel = tune_reg[`PPC_CAP_LSB +: 4];
    // band 0 has no table entry, so its delay falls to zero
    // duty-off set in band 0 is a software fault, the output stays zero anyway
    assign next_delay = duty_off ? 9'h000 : delay_lookup(band_q, duty_sel);
    assign next_cap_ff = (cap_sel[0] ? `PPC_CAP_UNIT_FF : 10'h000)
        + (cap_sel[1] ? (`PPC_CAP_UNIT_FF << 1) : 10'h000)
        + (cap_sel[2] ? (`PPC_CAP_UNIT_FF << 2) : 10'h000)
        + (cap_sel[3] ? (`PPC_CAP_UNIT_FF << 3) : 10'h000);
    assign next_slope = {1'b0, blocks_reg[`PPC_SLOPE_HI_LSB +: 2], slope_lo_reg} + 11'h001;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pa_drive <= '0;
        end else begin
            o_pa_drive.stage_en <= next_stage_en;
            o_pa_drive.blocks <= active.blocks;
            o_pa_drive.pa_on <= (stage_cnt != 4'h0) && (next_stage_en != 11'h000);
            o_pa_drive.delay_ps <= next_delay;
            o_pa_drive.cap_sel <= cap_sel;
            o_pa_drive.cap_ff <= next_cap_ff;
            o_pa_drive.slope_ratio <= next_slope;
        end
    end

    assign status_word = {22'h0, osc_q, band_q, set_q, o_pa_drive.pa_on, 1'b0, stage_cnt};

    // =========================================================
    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    chk_ready_wait: assert property (
        (i_psel && i_penable && !o_pready) |=> o_pready)
        else $error("no ready after one wait state");
    chk_ready_pulse: assert property (
        o_pready |=> !o_pready)
        else $error("ready held longer than one cycle");
    chk_ready_idle: assert property (
        !i_psel |=> !o_pready)
        else $error("ready without a selected transfer");
    chk_err_unmapped: assert property (
        (i_psel && i_penable && !o_pready && !idx_mapped) |=> o_pslverr)
        else $error("unmapped access not flagged");
    chk_err_with_ready: assert property (
        o_pslverr |-> o_pready)
        else $error("error shown outside the answer cycle");
    chk_data_with_ready: assert property (
        (o_prdata != 32'h0) |-> o_pready)
        else $error("read data shown outside the answer cycle");
    chk_early_accept: assert property (
        (i_psel && i_penable && !o_pready && !osc_q && idx_ok && writable) |=> !o_pslverr)
        else $error("write refused before oscillator settled");
    chk_strobe_gate: assert property (
        (access_done && i_pwrite && !i_pstrb[0] && reg_idx == `PPC_IDX_TUNE) |=> $stable(tune_reg))
        else $error("write landed without low byte strobe");

    // =========================================================
    // checks: amplifier settings
    chk_duty_table: assert property (
        (band_q == 2'h1 && !duty_off && duty_sel == 2'h3) |=> o_pa_drive.delay_ps == 9'h1E4)
        else $error("band 1 code 3 delay wrong");
    chk_band0_nodelay: assert property (
        band_q == 2'h0 |=> o_pa_drive.delay_ps == 9'h000)
        else $error("band 0 delay not zero");
    chk_duty_off: assert property (
        duty_off |=> o_pa_drive.delay_ps == 9'h000)
        else $error("duty off delay not zero");
    chk_block0_gate: assert property (
        !active.blocks[0] |=> o_pa_drive.stage_en[8:0] == 9'h000)
        else $error("block 0 stages lit while disabled");
    chk_full_stages: assert property (
        (active.blocks == 3'h7 && active.count == 4'hB) |=> o_pa_drive.stage_en == 11'h7FF)
        else $error("eleven stages not all lit");
    chk_count_clamp: assert property (
        (active.blocks == 3'h7 && active.count > 4'hB) |=> $countones(o_pa_drive.stage_en) == 11)
        else $error("count above 0xB not clamped");
    chk_zero_off: assert property (
        active.count == 4'h0 |=> !o_pa_drive.pa_on && o_pa_drive.stage_en == 11'h000)
        else $error("amplifier on with zero count");
    chk_slope_ratio: assert property (
        i_rst_n |=> o_pa_drive.slope_ratio
            == {1'b0, $past(blocks_reg[1:0]), $past(slope_lo_reg)} + 11'h001)
        else $error("slope ratio not code plus one");
    chk_cap_sum: assert property (
        cap_sel == 4'hF |=> o_pa_drive.cap_ff == 10'h384)
        else $error("cap total wrong");
    chk_early_write: assert property (
        (wr_en && !osc_q && reg_idx == `PPC_IDX_TUNE) |=> tune_reg == {1'b0, $past(i_pwdata[6:0])})
        else $error("write lost before oscillator settled");
    chk_set_choice: assert property (
        (set_q && set2.count == 4'h0 && set1.count != 4'h0) |=> !o_pa_drive.pa_on)
        else $error("wrong power setting applied");

    // =========================================================
    // checks: stage map, duty and tuning detail
    chk_block1_gate: assert property (
        !active.blocks[1] |=> !o_pa_drive.stage_en[9])
        else $error("block 1 stage lit while disabled");
    chk_block2_gate: assert property (
        !active.blocks[2] |=> !o_pa_drive.stage_en[10])
        else $error("block 2 stage lit while disabled");
    chk_block0_span: assert property (
        (active.blocks[0] && active.count >= 4'h9) |=> o_pa_drive.stage_en[8:0] == 9'h1FF)
        else $error("block 0 not nine stages wide");
    chk_stage_count: assert property (
        (active.blocks == 3'h7 && active.count <= 4'hB)
            |=> $countones(o_pa_drive.stage_en) == $past(active.count))
        else $error("lit stages differ from count");
    chk_pa_on_lit: assert property (
        (active.count != 4'h0 && active.blocks[0]) |=> o_pa_drive.pa_on)
        else $error("amplifier off with stages lit");
    chk_blocks_out: assert property (
        i_rst_n |=> o_pa_drive.blocks == $past(active.blocks))
        else $error("block enables not from active setting");
    chk_set1_choice: assert property (
        (!set_q && set1.count == 4'h0 && set2.count != 4'h0) |=> !o_pa_drive.pa_on)
        else $error("setting 2 applied while setting 1 selected");
    chk_delay_band2: assert property (
        (band_q == 2'h2 && !duty_off && duty_sel == 2'h0) |=> o_pa_drive.delay_ps == 9'h023)
        else $error("band 2 code 0 delay wrong");
    chk_delay_band3: assert property (
        (band_q == 2'h3 && !duty_off && duty_sel == 2'h1) |=> o_pa_drive.delay_ps == 9'h062)
        else $error("band 3 code 1 delay wrong");
    chk_cap_single: assert property (
        cap_sel == 4'h8 |=> o_pa_drive.cap_ff == 10'h1E0)
        else $error("top cap bank value wrong");
    chk_cap_switch: assert property (
        i_rst_n |=> o_pa_drive.cap_sel == $past(cap_sel))
        else $error("cap switches not passed through");
    chk_slope_min: assert property (
        (i_rst_n && {blocks_reg[1:0], slope_lo_reg} == 10'h000) |=> o_pa_drive.slope_ratio == 11'h001)
        else $error("slope code 0 not divide by one");
    chk_slope_max: assert property (
        ({blocks_reg[1:0], slope_lo_reg} == 10'h3FF) |=> o_pa_drive.slope_ratio == 11'h400)
        else $error("slope code 0x3FF not divide by 1024");

endmodule // ppc_power_config_regs

// ---- sim/ppc_power_config_regs_tb.sv ----
`timescale 1ns/1ps
module ppc_power_config_regs_tb;
    import ppc_pkg::*;
    // ==========
    // stimulus and observation
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] band = 2'h0;
    logic set_sel = 1'b0;
    logic osc_ok = 1'b0;
    logic [3:0] pstrb = 4'hF;
    logic o_pready;
    logic [31:0] o_prdata;
    logic o_pslverr;
    ppc_pa_drive_s o_pa_drive;
    int bad_count = 0;
    int n_tests = 0;
    // inserted delay per band and duty code, band 0 never delays
    logic [8:0] dly [4][4] = '{'{9'h000, 9'h000, 9'h000, 9'h000},
        '{9'h045, 9'h0CF, 9'h15A, 9'h1E4}, '{9'h023, 9'h068, 9'h0AD, 9'h0F2},
        '{9'h021, 9'h062, 9'h0A4, 9'h0E6}};
    // block/count pairs: boundaries of the clamp and of each block
    logic [2:0] cblk [7] = '{3'h1, 3'h7, 3'h7, 3'h6, 3'h4, 3'h3, 3'h7};
    logic [3:0] ccnt [7] = '{4'h9, 4'hF, 4'h0, 4'hA, 4'hB, 4'hC, 4'hB};
    always #20 i_core_clk = ~i_core_clk;
    ppc_power_config_regs u_ppc_power_config_regs (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
        .i_band_select(band), .i_set_select(set_sel), .i_osc_settled(osc_ok),
        .o_pa_drive(o_pa_drive));
    // ==========
    // helpers
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [31:0] a, input logic [7:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge i_core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge i_core_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            final_report();
        end
        rd = o_prdata;
        err = o_pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic acc(input logic wr, input logic [31:0] a, input logic [7:0] d,
                       input logic experr);
        logic [31:0] rd;
        logic err;
        apb(wr, a, d, rd, err);
        check(err, experr);
        if (!wr) check(rd, 64'h0);
    endtask
    function automatic logic [10:0] stages(input logic [2:0] blk, input logic [3:0] cnt);
        logic [10:0] s;
        int n;
        n = (cnt > 4'hB) ? 11 : int'(cnt);
        for (int i = 0; i < 11; i++) begin
            s[i] = (i < n) && blk[(i < 9) ? 0 : i - 8];
        end
        return s;
    endfunction
    // ==========
    // sequence
    initial begin
        logic [10:0] e;
        logic [31:0] rd;
        logic err;
        int k;
        repeat (3) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        tick(3);
        check(o_pa_drive, 64'(49'h1));
        // oscillator still unsettled: registers must work anyway
        for (int c = 0; c < 16; c++) begin
            acc(1'b1, 32'h7C, {4'h0, 4'(c)}, 1'b0);
            tick(3);
            check(o_pa_drive.cap_sel, 64'(c));
            check(o_pa_drive.cap_ff, 64'(60 * c));
        end
        // low byte strobe off: write dropped, no error
        @(posedge i_core_clk);
        pstrb <= 4'h0;
        acc(1'b1, 32'h7C, 8'h05, 1'b0);
        pstrb <= 4'hF;
        tick(3);
        check(o_pa_drive.cap_sel, 64'hF);
        @(posedge i_core_clk);
        osc_ok <= 1'b1;
        for (int b = 0; b < 4; b++) begin
            @(posedge i_core_clk);
            band <= 2'(b);
            tick(6);
            for (int c = 0; c < 4; c++) begin
                acc(1'b1, 32'h7C, {2'b00, 2'(c), 4'h3}, 1'b0);
                tick(3);
                check(o_pa_drive.delay_ps, 64'(dly[b][c]));
            end
            if (b != 0) begin
                acc(1'b1, 32'h7C, 8'h70, 1'b0);
                tick(3);
                check(o_pa_drive.delay_ps, 64'h0);
            end
        end
        for (int i = 0; i < 7; i++) begin
            k = (i + 1) % 7;
            acc(1'b1, 32'h68, {cblk[k], cblk[i], 2'b00}, 1'b0);
            acc(1'b1, 32'h6C, {ccnt[k], ccnt[i]}, 1'b0);
            for (int s = 0; s < 2; s++) begin
                @(posedge i_core_clk);
                set_sel <= 1'(s);
                tick(6);
                k = s ? (i + 1) % 7 : i;
                e = stages(cblk[k], ccnt[k]);
                check(o_pa_drive.stage_en, 64'(e));
                check(o_pa_drive.blocks, 64'(cblk[k]));
                check(o_pa_drive.pa_on, 64'(ccnt[k] != 0 && e != 0));
            end
        end
        // divider code split over two registers
        acc(1'b1, 32'h68, 8'h03, 1'b0);
        acc(1'b1, 32'h84, 8'hFF, 1'b0);
        tick(3);
        check(o_pa_drive.slope_ratio, 64'h400);
        acc(1'b1, 32'h68, 8'h02, 1'b0);
        acc(1'b1, 32'h84, 8'h00, 1'b0);
        tick(3);
        check(o_pa_drive.slope_ratio, 64'h201);
        // status: osc 1, band 3, setting 2 active with count 9, no block on
        apb(1'b0, 32'h80, 8'h00, rd, err);
        check(rd, 64'h3C9);
        check(err, 64'h0);
        // unmapped, read-only and write-only places
        acc(1'b0, 32'h88, 8'h00, 1'b1);
        acc(1'b1, 32'h80, 8'h00, 1'b1);
        acc(1'b0, 32'h68, 8'h00, 1'b0);
        // reset in mid-run: outputs clear, defaults come back
        @(posedge i_core_clk);
        i_rst_n <= 1'b0;
        tick(2);
        check(o_pa_drive, 64'h0);
        @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        tick(6);
        check(o_pa_drive.delay_ps, 64'h0A4);
        check(o_pa_drive.stage_en, 64'h0);
        apb(1'b0, 32'h80, 8'h00, rd, err);
        check(rd, 64'h3C0);
        final_report();
    end
endmodule // ppc_power_config_regs_tb
